// File: mtlb_top.v
// Purpose: translation unit front end with buffer, walk request and checks
// Assumes: walker returns a decoded descriptor; core holds request until done
// Notes:   one access at a time; registers reached by coprocessor transfers
`include "mtlb_regs.vh"
`default_nettype none

module mtlb_top #(
  parameter ENTRIES = 64,
  parameter PW      = 6
) (
  input  wire        clock,           // core clock, 40 MHz
  input  wire        rstn,            // sync reset, active low
  input  wire        cp_wr,           // core_to_coproc_transfer strobe
  input  wire        cp_rd,           // coproc_to_core_transfer strobe
  input  wire [3:0]  cp_reg,          // register number
  input  wire        cp_op,           // maintenance: 0 all, 1 one entry
  input  wire [31:0] cp_wdata,        // write data
  output reg  [31:0] cp_rdata,        // read data, one cycle after cp_rd
  input  wire        acc_valid,       // access request
  input  wire [31:0] acc_va,          // modified_virtual_address
  input  wire        acc_write,       // write access
  input  wire        acc_priv,        // privileged access
  input  wire [1:0]  acc_size,        // 0 byte, 1 half, 2 word
  input  wire        cache_holds,     // cache can serve the access
  output reg         busy,            // access in progress
  output reg         acc_done,        // access finished, one pulse
  output reg         acc_ext,         // external transfer needed
  output reg         acc_cache,       // served by the cache
  output reg         acc_abort,       // abort to the core
  output reg  [31:0] acc_pa,          // physical address
  output reg         acc_cachable,    // region cachable
  output reg         acc_bufferable,  // region bufferable
  output reg         walk_req,        // table walk request
  output reg  [31:0] walk_addr,       // level one descriptor address
  input  wire        walk_ack,        // walk result valid
  input  wire        walk_fault,      // walk found no translation
  input  wire        walk_page,       // fault came from a page table
  input  wire [1:0]  walk_size,       // mapping size
  input  wire [21:0] walk_pa,         // physical base bits 31:10
  input  wire [3:0]  walk_dom,        // domain number
  input  wire [7:0]  walk_ap,         // subpage permissions
  input  wire        walk_c,          // cachable
  input  wire        walk_b           // bufferable
);

  // access sequencer states
  localparam ST_IDLE = 2'h0;
  localparam ST_LOOK = 2'h1;
  localparam ST_WALK = 2'h2;

  // held access and management registers
  reg [1:0]  state_q;
  reg [31:0] va_q;
  reg        wr_q;
  reg        priv_q;
  reg [1:0]  sz_q;
  reg [31:0] ctrl_q;
  reg [17:0] tbase_q;
  reg [31:0] dom_q;
  reg [7:0]  cause_q;
  reg [31:0] fva_q;

  // buffer lookup and permission results
  wire        hit;
  wire [21:0] hit_pa;
  wire [1:0]  hit_size;
  wire [3:0]  hit_dom;
  wire [7:0]  hit_ap;
  wire        hit_c;
  wire        hit_b;
  wire        dom_fault;
  wire        perm_fault;

  // decode of the looked-up entry
  reg  [1:0]  sub_ap;
  reg  [31:0] xlat_pa;
  reg  [31:0] rd_mux;
  reg         abort_now;
  reg  [3:0]  abort_code;
  reg  [3:0]  abort_dom;

  // conditions derived from the held access
  wire mmu_on   = ctrl_q[`MTLB_CTRL_EN];
  wire misalign = ctrl_q[`MTLB_CTRL_ALIGN] &
                  ((sz_q == 2'h2 && va_q[1:0] != 2'h0) || (sz_q == 2'h1 && va_q[0]));
  wire is_sec   = hit_size == `MTLB_SZ_SECTION;
  wire refill   = state_q == ST_WALK && walk_ack && !walk_fault;
  wire maint    = cp_wr && cp_reg == `MTLB_REG_MAINT;
  wire [1:0] dom_mode = dom_q[{hit_dom, 1'b0} +: 2];

  // ------------------------------------------------------------
  // translation buffer and permission check
  // ------------------------------------------------------------
  // lookup runs on the held address, refill on a good walk answer
  mtlb_tlb_array #(
    .ENTRIES (ENTRIES),
    .PW      (PW)
  ) u_tlb (
    .clock    (clock),
    .rstn     (rstn),
    .look_va  (va_q),
    .hit      (hit),
    .hit_pa   (hit_pa),
    .hit_size (hit_size),
    .hit_dom  (hit_dom),
    .hit_ap   (hit_ap),
    .hit_c    (hit_c),
    .hit_b    (hit_b),
    .wr_en    (refill),
    .wr_size  (walk_size),
    .wr_pa    (walk_pa),
    .wr_dom   (walk_dom),
    .wr_ap    (walk_ap),
    .wr_c     (walk_c),
    .wr_b     (walk_b),
    .inv_all  (maint && cp_op == `MTLB_OP_INV_ALL),
    .inv_one  (maint && cp_op == `MTLB_OP_INV_ONE),
    .inv_va   (cp_wdata)
  );

  // permission check of the selected subpage
  mtlb_perm_check u_perm (
    .dom_mode   (dom_mode),
    .ap         (sub_ap),
    .sys_bit    (ctrl_q[`MTLB_CTRL_SYS]),
    .rom_bit    (ctrl_q[`MTLB_CTRL_ROM]),
    .priv       (priv_q),
    .write      (wr_q),
    .dom_fault  (dom_fault),
    .perm_fault (perm_fault)
  );

  // ------------------------------------------------------------
  // subpage permission select and physical address
  // ------------------------------------------------------------
  always @* begin
    case (hit_size)
      `MTLB_SZ_LARGE: begin
        sub_ap  = hit_ap[{va_q[15:14], 1'b0} +: 2];
        xlat_pa = {hit_pa[21:6], va_q[15:0]};
      end
      `MTLB_SZ_SMALL: begin
        sub_ap  = hit_ap[{va_q[11:10], 1'b0} +: 2];
        xlat_pa = {hit_pa[21:2], va_q[11:0]};
      end
      `MTLB_SZ_TINY: begin
        sub_ap  = hit_ap[1:0];
        xlat_pa = {hit_pa, va_q[9:0]};
      end
      default: begin
        sub_ap  = hit_ap[1:0];
        xlat_pa = {hit_pa[21:10], va_q[19:0]};
      end
    endcase
  end

  // abort decision for the looked-up access
  always @* begin
    abort_now  = 1'b0;
    abort_code = 4'h0;
    abort_dom  = 4'h0;
    if (state_q == ST_LOOK) begin
      if (misalign) begin
        abort_now  = 1'b1;
        abort_code = `MTLB_FS_ALIGN;
      end else if (mmu_on && hit && dom_fault) begin
        abort_now  = 1'b1;
        abort_dom  = hit_dom;
        abort_code = is_sec ? `MTLB_FS_DOM_SEC : `MTLB_FS_DOM_PG;
      end else if (mmu_on && hit && perm_fault) begin
        abort_now  = 1'b1;
        abort_dom  = hit_dom;
        abort_code = is_sec ? `MTLB_FS_PERM_SEC : `MTLB_FS_PERM_PG;
      end
    end else if (state_q == ST_WALK && walk_ack && walk_fault) begin
      abort_now  = 1'b1;
      abort_dom  = walk_dom;
      abort_code = walk_page ? `MTLB_FS_TRANS_PG : `MTLB_FS_TRANS_SEC;
    end
  end

  // ------------------------------------------------------------
  // access sequencer
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rstn) begin
      state_q        <= ST_IDLE;
      va_q           <= 32'h00000000;
      wr_q           <= 1'b0;
      priv_q         <= 1'b0;
      sz_q           <= 2'h0;
      busy           <= 1'b0;
      acc_done       <= 1'b0;
      acc_ext        <= 1'b0;
      acc_cache      <= 1'b0;
      acc_abort      <= 1'b0;
      acc_pa         <= 32'h00000000;
      acc_cachable   <= 1'b0;
      acc_bufferable <= 1'b0;
      walk_req       <= 1'b0;
      walk_addr      <= 32'h00000000;
    end else begin
      // result strobes are one-cycle pulses
      acc_done  <= 1'b0;
      acc_ext   <= 1'b0;
      acc_cache <= 1'b0;
      acc_abort <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // only an idle sequencer takes a request
          if (acc_valid) begin
            va_q    <= acc_va;
            wr_q    <= acc_write;
            priv_q  <= acc_priv;
            sz_q    <= acc_size;
            busy    <= 1'b1;
            state_q <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          if (abort_now) begin
            acc_done  <= 1'b1;
            acc_abort <= 1'b1;
            busy      <= 1'b0;
            state_q   <= ST_IDLE;
          end else if (!mmu_on) begin
            acc_done       <= 1'b1;
            acc_ext        <= 1'b1;
            acc_pa         <= va_q;
            acc_cachable   <= 1'b0;
            acc_bufferable <= 1'b0;
            busy           <= 1'b0;
            state_q        <= ST_IDLE;
          end else if (hit) begin
            acc_done       <= 1'b1;
            acc_pa         <= xlat_pa;
            acc_cachable   <= hit_c;
            acc_bufferable <= hit_b;
            acc_cache      <= hit_c & cache_holds;
            acc_ext        <= ~(hit_c & cache_holds);
            busy           <= 1'b0;
            state_q        <= ST_IDLE;
          end else begin
            walk_req  <= 1'b1;
            walk_addr <= {tbase_q, va_q[31:20], 2'h0};
            state_q   <= ST_WALK;
          end
        end
        ST_WALK: begin
          if (walk_ack) begin
            walk_req <= 1'b0;
            if (walk_fault) begin
              acc_done  <= 1'b1;
              acc_abort <= 1'b1;
              busy      <= 1'b0;
              state_q   <= ST_IDLE;
            end else begin
              state_q <= ST_LOOK;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // management registers, hardware abort update wins over software
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rstn) begin
      ctrl_q  <= `MTLB_CTRL_RST;
      tbase_q <= `MTLB_TBASE_RST;
      dom_q   <= `MTLB_DOMAIN_RST;
      cause_q <= `MTLB_CAUSE_RST;
      fva_q   <= `MTLB_ADDR_RST;
    end else begin
      if (cp_wr) begin
        case (cp_reg)
          `MTLB_REG_CTRL:   ctrl_q  <= cp_wdata;
          `MTLB_REG_TBASE:  tbase_q <= cp_wdata[31:`MTLB_TBASE_LSB];
          `MTLB_REG_DOMAIN: dom_q   <= cp_wdata;
          `MTLB_REG_CAUSE:  cause_q <= cp_wdata[7:0];
          `MTLB_REG_ADDR:   fva_q   <= cp_wdata;
          default: ;
        endcase
      end
      // hardware abort capture beats a software write
      if (abort_now) begin
        cause_q <= {abort_dom, abort_code};
        fva_q   <= va_q;
      end
    end
  end

  // read mux, maintenance register reads as zero
  always @* begin
    case (cp_reg)
      `MTLB_REG_CTRL:   rd_mux = ctrl_q;
      `MTLB_REG_TBASE:  rd_mux = {tbase_q, 14'h0000};
      `MTLB_REG_DOMAIN: rd_mux = dom_q;
      `MTLB_REG_CAUSE:  rd_mux = {24'h000000, cause_q};
      `MTLB_REG_ADDR:   rd_mux = fva_q;
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // registered read data
  always @(posedge clock) begin
    if (!rstn)
      cp_rdata <= 32'h00000000;
    else if (cp_rd)
      cp_rdata <= rd_mux;
  end

endmodule

`default_nettype wire

// File: mtlb_regs.vh
// Purpose: constants of the translation unit front end
// Assumes: registers are selected by a 4-bit register number
// Notes:   definitions only
`ifndef MTLB_REGS_VH
`define MTLB_REGS_VH

// ------------------------------------------------------------
// register numbers
// ------------------------------------------------------------
`define MTLB_REG_CTRL     4'h1
`define MTLB_REG_TBASE    4'h2
`define MTLB_REG_DOMAIN   4'h3
`define MTLB_REG_CAUSE    4'h5
`define MTLB_REG_ADDR     4'h6
`define MTLB_REG_MAINT    4'h8

// ------------------------------------------------------------
// control bit positions and reset values
// ------------------------------------------------------------
`define MTLB_CTRL_EN      0
`define MTLB_CTRL_ALIGN   1
`define MTLB_CTRL_SYS     8
`define MTLB_CTRL_ROM     9
`define MTLB_CTRL_RST     32'h00000000
`define MTLB_TBASE_LSB    14
`define MTLB_TBASE_RST    18'h00000
`define MTLB_DOMAIN_RST   32'h00000000
`define MTLB_CAUSE_RST    8'h00
`define MTLB_ADDR_RST     32'h00000000

// ------------------------------------------------------------
// maintenance operations, mapping sizes, domain modes
// ------------------------------------------------------------
`define MTLB_OP_INV_ALL   1'b0
`define MTLB_OP_INV_ONE   1'b1
`define MTLB_SZ_SECTION   2'h0
`define MTLB_SZ_LARGE     2'h1
`define MTLB_SZ_SMALL     2'h2
`define MTLB_SZ_TINY      2'h3
`define MTLB_DOM_NONE     2'h0
`define MTLB_DOM_CLIENT   2'h1
`define MTLB_DOM_MANAGER  2'h3

// ------------------------------------------------------------
// abort cause codes
// ------------------------------------------------------------
`define MTLB_FS_ALIGN     4'h1
`define MTLB_FS_TRANS_SEC 4'h5
`define MTLB_FS_TRANS_PG  4'h7
`define MTLB_FS_DOM_SEC   4'h9
`define MTLB_FS_DOM_PG    4'hb
`define MTLB_FS_PERM_SEC  4'hd
`define MTLB_FS_PERM_PG   4'hf

`endif

// File: mtlb_perm_check.v
// Purpose: domain and access permission check for one access
// Assumes: ap already selected for the subpage being accessed
// Notes:   purely combinational
`include "mtlb_regs.vh"
`default_nettype none

module mtlb_perm_check (
  input  wire [1:0] dom_mode,   // domain field of the access
  input  wire [1:0] ap,         // permission field
  input  wire       sys_bit,    // protection modifier s
  input  wire       rom_bit,    // protection modifier r
  input  wire       priv,       // privileged access
  input  wire       write,      // write access
  output reg        dom_fault,  // domain aborts access
  output reg        perm_fault  // permission denies access
);

  // ------------------------------------------------------------
  // domain mode then permission decode
  // ------------------------------------------------------------
  always @* begin
    dom_fault  = 1'b0;
    perm_fault = 1'b0;
    case (dom_mode)
      `MTLB_DOM_MANAGER: perm_fault = 1'b0;
      `MTLB_DOM_CLIENT: begin
        case (ap)
          2'h0: perm_fault = write | ~((sys_bit & priv) | rom_bit);
          2'h1: perm_fault = ~priv;
          2'h2: perm_fault = ~priv & write;
          default: perm_fault = 1'b0;
        endcase
      end
      default: dom_fault = 1'b1;
    endcase
  end

endmodule

`default_nettype wire

// File: mtlb_tlb_array.v
// Purpose: fully associative translation buffer with cyclic refill
// Assumes: tag and physical base kept at 1KB granularity
// Notes:   lookup is combinational, updates on the clock
`include "mtlb_regs.vh"
`default_nettype none

module mtlb_tlb_array #(
  parameter ENTRIES = 64,
  parameter PW      = 6
) (
  input  wire        clock,     // core clock
  input  wire        rstn,      // sync reset, active low
  input  wire [31:0] look_va,   // address looked up
  output reg         hit,       // an entry matches
  output reg  [21:0] hit_pa,    // physical base bits 31:10
  output reg  [1:0]  hit_size,  // mapping size
  output reg  [3:0]  hit_dom,   // domain number
  output reg  [7:0]  hit_ap,    // four subpage permissions
  output reg         hit_c,     // cachable
  output reg         hit_b,     // bufferable
  input  wire        wr_en,     // refill strobe
  input  wire [1:0]  wr_size,   // refill size
  input  wire [21:0] wr_pa,     // refill physical base
  input  wire [3:0]  wr_dom,    // refill domain
  input  wire [7:0]  wr_ap,     // refill permissions
  input  wire        wr_c,      // refill cachable
  input  wire        wr_b,      // refill bufferable
  input  wire        inv_all,   // invalidate whole buffer
  input  wire        inv_one,   // invalidate matching entry
  input  wire [31:0] inv_va     // address to invalidate
);

  reg [21:0]      tag_q [0:ENTRIES-1];
  reg [1:0]       size_q [0:ENTRIES-1];
  reg [21:0]      pa_q [0:ENTRIES-1];
  reg [13:0]      attr_q [0:ENTRIES-1];
  reg [ENTRIES-1:0] valid_q;
  reg [PW-1:0]    rr_q;
  wire [ENTRIES-1:0] look_m;
  wire [ENTRIES-1:0] inv_m;
  integer i;

  // compare address with a tag under the size mask
  function match;
    input [21:0] tag;
    input [1:0]  sz;
    input [31:0] va;
    reg   [21:0] mask;
    begin
      case (sz)
        `MTLB_SZ_SECTION: mask = 22'h3ffc00;
        `MTLB_SZ_LARGE:   mask = 22'h3fffc0;
        `MTLB_SZ_SMALL:   mask = 22'h3ffffc;
        default:          mask = 22'h3fffff;
      endcase
      match = ((tag ^ va[31:10]) & mask) == 22'h000000;
    end
  endfunction

  // ------------------------------------------------------------
  // per entry comparators
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < ENTRIES; g = g + 1) begin : cmp
      assign look_m[g] = valid_q[g] & match(tag_q[g], size_q[g], look_va);
      assign inv_m[g]  = valid_q[g] & match(tag_q[g], size_q[g], inv_va);
    end
  endgenerate

  // hit mux, protection information of the matching entry
  always @* begin
    hit = 1'b0;
    hit_pa = 22'h000000;
    hit_size = 2'h0;
    hit_dom = 4'h0;
    hit_ap = 8'h00;
    hit_c = 1'b0;
    hit_b = 1'b0;
    for (i = 0; i < ENTRIES; i = i + 1) begin
      if (look_m[i] && !hit) begin
        hit = 1'b1;
        hit_pa = pa_q[i];
        hit_size = size_q[i];
        {hit_dom, hit_ap, hit_c, hit_b} = attr_q[i];
      end
    end
  end

  // refill at the cyclic pointer, then invalidates
  always @(posedge clock) begin
    if (!rstn) begin
      valid_q <= {ENTRIES{1'b0}};
      rr_q    <= {PW{1'b0}};
    end else begin
      if (wr_en) begin
        tag_q[rr_q]   <= look_va[31:10];
        size_q[rr_q]  <= wr_size;
        pa_q[rr_q]    <= wr_pa;
        attr_q[rr_q]  <= {wr_dom, wr_ap, wr_c, wr_b};
        valid_q[rr_q] <= 1'b1;
        rr_q          <= rr_q + {{(PW-1){1'b0}}, 1'b1};
      end
      if (inv_all)
        valid_q <= {ENTRIES{1'b0}};
      else if (inv_one)
        valid_q <= valid_q & ~inv_m;
    end
  end

endmodule

`default_nettype wire

// File: mtlb_walk_model.sv
// Purpose: table walk responder standing beside the front end
// Assumes: one walk at a time, answer LAG+1 cycles after the request
// Notes:   mapping size from va bits 27:26; top address 12'hfff has no translation
`default_nettype none
module mtlb_walk_model #(
  parameter int LAG = 3
) (
  input  wire logic        clock,      // core clock
  input  wire logic        rstn,       // sync reset, active low
  input  wire logic        walk_req,   // walk request
  input  wire logic [31:0] walk_addr,  // descriptor address
  output var  logic        walk_ack,   // answer pulse
  output wire logic        walk_fault, // no translation
  output wire logic        walk_page,  // page level fault
  output wire logic [1:0]  walk_size,  // mapping size
  output wire logic [21:0] walk_pa,    // physical base
  output wire logic [3:0]  walk_dom,   // domain
  output wire logic [7:0]  walk_ap,    // permissions
  output wire logic        walk_c,     // cachable
  output wire logic        walk_b,     // bufferable
  output var  int          walks       // walks answered
);
  logic [39:0] pay;
  logic [11:0] vhi;
  int          cnt;
  assign vhi = walk_addr[13:2];
  assign {walk_fault, walk_page, walk_size, walk_pa, walk_dom, walk_ap, walk_c, walk_b} = pay;
  // -------------------------------------------------
  // answer; payload toggles while not answering
  // -------------------------------------------------
  always @(posedge clock) begin
    walk_ack <= 1'b0;
    pay      <= ~pay;
    if (!rstn) begin
      cnt   <= 0;
      walks <= 0;
    end else if (walk_req && !walk_ack) begin
      cnt <= cnt + 1;
      if (cnt == LAG) begin
        cnt      <= 0;
        walks    <= walks + 1;
        walk_ack <= 1'b1;
        // subpages 0..3: privileged only, none, user read, all
        pay      <= {vhi == 12'hfff, 1'b0, vhi[7:6], vhi ^ 12'h800, 10'h0, vhi[3:0], 8'he1, 2'h3};
      end
    end
  end
endmodule
`default_nettype wire

// File: mtlb_chk_properties.sv
// Purpose: port checks of the translation front end
// Assumes: core holds acc_va until the result
// Notes:   bound into mtlb_top
`default_nettype none
module mtlb_chk (
  input wire logic        clock,     // core clock
  input wire logic        rstn,      // sync reset
  input wire logic        cp_rd,     // read strobe
  input wire logic [3:0]  cp_reg,    // register number
  input wire logic [31:0] cp_rdata,  // read data
  input wire logic        acc_valid, // access request
  input wire logic [31:0] acc_va,    // access address
  input wire logic        busy,      // access running
  input wire logic        acc_done,  // result pulse
  input wire logic        acc_ext,   // external
  input wire logic        acc_cache, // cache served
  input wire logic        acc_abort, // abort
  input wire logic        walk_req,  // walk request
  input wire logic        walk_ack,  // walk answer
  input wire logic        walk_fault,// walk fault
  input wire logic [31:0] walk_addr  // descriptor address
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // -------------------------------------------------
  // checks
  // -------------------------------------------------
  done_pulse_a: assert property (acc_done |=> !acc_done) else $error("done too long");
  one_result_a: assert property ((acc_ext || acc_cache || acc_abort) |-> acc_done &&
    $onehot({acc_ext, acc_cache, acc_abort})) else $error("bad result set");
  answer_time_a: assert property (acc_valid && !busy |-> ##2 (acc_done || walk_req)) else $error("late");
  walk_hold_a: assert property (walk_req && !walk_ack |=> walk_req) else $error("walk dropped");
  refill_done_a: assert property (walk_req && walk_ack && !walk_fault |=> !walk_req ##1 acc_done)
    else $error("refill result late");
  walk_addr_a: assert property (walk_req |-> walk_addr[13:0] == {acc_va[31:20], 2'h0})
    else $error("walk address");
  tbase_low_a: assert property (cp_rd && cp_reg == 4'h2 |=> cp_rdata[13:0] == 14'h0) else $error("base");
  maint_read_a: assert property (cp_rd && cp_reg == 4'h8 |=> cp_rdata == 32'h0) else $error("maint");
  cause_high_a: assert property (cp_rd && cp_reg == 4'h5 |=> cp_rdata[31:8] == 24'h0) else $error("cause");
  cover property (acc_abort);
  cover property (acc_cache);
  cover property (walk_ack && walk_fault);
endmodule
bind mtlb_top mtlb_chk mtlb_chk_i (.clock(clock), .rstn(rstn), .cp_rd(cp_rd), .cp_reg(cp_reg),
  .cp_rdata(cp_rdata), .acc_valid(acc_valid), .acc_va(acc_va), .busy(busy), .acc_done(acc_done),
  .acc_ext(acc_ext), .acc_cache(acc_cache), .acc_abort(acc_abort), .walk_req(walk_req),
  .walk_ack(walk_ack), .walk_fault(walk_fault), .walk_addr(walk_addr));
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench of the translation front end
// Assumes: walks answered by mtlb_walk_model
// Notes:   register and access calls with expected values
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] VA = 32'h00300010;
  logic        clock = 0, rstn = 0, cp_wr = 0, cp_rd = 0, cp_op = 0, acc_valid = 0, acc_priv = 0;
  logic        cache_holds = 0, acc_write = 0, busy, acc_done, acc_ext, acc_cache, acc_abort, acc_cachable;
  logic        acc_bufferable, walk_req, walk_ack, walk_fault, walk_page, walk_c, walk_b;
  logic [1:0]  acc_size = 2, walk_size;
  logic [3:0]  cp_reg = 0, walk_dom;
  logic [7:0]  walk_ap;
  logic [21:0] walk_pa;
  logic [31:0] cp_wdata = 0, acc_va = 0, cp_rdata, acc_pa, walk_addr;
  logic [2:0]  res;
  int          walks, miscompares = 0, checked = 0;
  logic [3:0]  mtlb_regs_list [5] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6};
  always #12.5 clock = ~clock;
  mtlb_top mtlb_top_i (.clock(clock), .rstn(rstn), .cp_wr(cp_wr), .cp_rd(cp_rd), .cp_reg(cp_reg),
    .cp_op(cp_op), .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .acc_valid(acc_valid), .acc_va(acc_va),
    .acc_write(acc_write), .acc_priv(acc_priv), .acc_size(acc_size), .cache_holds(cache_holds),
    .busy(busy), .acc_done(acc_done), .acc_ext(acc_ext), .acc_cache(acc_cache), .acc_abort(acc_abort),
    .acc_pa(acc_pa), .acc_cachable(acc_cachable), .acc_bufferable(acc_bufferable),
    .walk_req(walk_req), .walk_addr(walk_addr), .walk_ack(walk_ack), .walk_fault(walk_fault),
    .walk_page(walk_page), .walk_size(walk_size), .walk_pa(walk_pa), .walk_dom(walk_dom),
    .walk_ap(walk_ap), .walk_c(walk_c), .walk_b(walk_b));
  mtlb_walk_model mtlb_walk_model_i (.clock(clock), .rstn(rstn), .walk_req(walk_req),
    .walk_addr(walk_addr), .walk_ack(walk_ack), .walk_fault(walk_fault), .walk_page(walk_page),
    .walk_size(walk_size), .walk_pa(walk_pa), .walk_dom(walk_dom), .walk_ap(walk_ap),
    .walk_c(walk_c), .walk_b(walk_b), .walks(walks));
  // -------------------------------------------------
  // tasks
  // -------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] r, input logic o, input logic [31:0] v);
    @(posedge clock);
    cp_wr    <= 1;
    cp_reg   <= r;
    cp_op    <= o;
    cp_wdata <= v;
    @(posedge clock);
    cp_wr <= 0;
  endtask
  task automatic rc(input logic [3:0] r, input logic [31:0] e);
    @(posedge clock);
    cp_rd  <= 1;
    cp_reg <= r;
    @(posedge clock);
    cp_rd <= 0;
    #1 chk("register", e, cp_rdata);
  endtask
  task automatic acc(input logic [31:0] va, input logic p, input logic h, input logic [1:0] s,
                     input logic w = 1'b0);
    int n;
    @(posedge clock);
    acc_valid   <= 1;
    acc_va      <= va;
    acc_priv    <= p;
    cache_holds <= h;
    acc_size    <= s;
    acc_write   <= w;
    #1;
    for (n = 0; n < 100 && acc_done !== 1'b1; n++) begin
      @(posedge clock);
      acc_valid <= 0;
      #1;
    end
    if (acc_done !== 1'b1) begin
      miscompares++;
      print_verdict;
    end
    res = {acc_ext, acc_cache, acc_abort};
  endtask
  task automatic ca(input logic [2:0] r, input logic [31:0] pa);
    chk("result", {29'h0, r}, {29'h0, res});
    if (r == 3'b100) chk("pa", pa, acc_pa);
  endtask
  // -------------------------------------------------
  // sequence
  // -------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1;
    foreach (mtlb_regs_list[i]) rc(mtlb_regs_list[i], 32'h0);
    wr(4'h3, 0, 32'h55555555);
    rc(4'h3, 32'h55555555);
    wr(4'h2, 0, 32'hffffffff);
    rc(4'h2, 32'hffffc000);
    rc(4'h8, 32'h0);
    acc(32'h12345678, 1, 1, 2);
    ca(3'b100, 32'h12345678);
    chk("cb", 32'h0, {30'h0, acc_cachable, acc_bufferable});
    wr(4'h2, 0, 32'h0);
    wr(4'h1, 0, 32'h1);
    acc(VA, 1, 0, 2);
    ca(3'b100, 32'h80300010);
    chk("cb", 32'h3, {30'h0, acc_cachable, acc_bufferable});
    chk("walks", 32'h1, walks);
    acc(VA, 1, 1, 2);
    ca(3'b010, 32'h0);
    chk("walks", 32'h1, walks);
    acc(VA, 0, 1, 2);
    ca(3'b001, 32'h0);
    rc(4'h5, 32'h3d);
    rc(4'h6, VA);
    wr(4'h3, 0, 32'hffffffff);
    acc(VA, 0, 0, 2);
    ca(3'b100, 32'h80300010);
    wr(4'h3, 0, 32'h0);
    acc(VA, 1, 0, 2);
    ca(3'b001, 32'h0);
    rc(4'h5, 32'h39);
    wr(4'h3, 0, 32'h55555555);
    wr(4'h8, 1, VA);
    acc(VA, 1, 0, 2);
    chk("walks", 32'h2, walks);
    wr(4'h8, 0, 32'h0);
    acc(VA, 1, 0, 2);
    chk("walks", 32'h3, walks);
    acc(32'hfff00000, 1, 0, 2);
    ca(3'b001, 32'h0);
    rc(4'h5, 32'hf5);
    wr(4'h1, 0, 32'h3);
    acc(32'h00300012, 1, 0, 2);
    ca(3'b001, 32'h0);
    rc(4'h5, 32'h01);
    wr(4'h6, 0, 32'h0a5a0a5a);
    rc(4'h6, 32'h0a5a0a5a);
    acc(32'h04300010, 0, 0, 2);
    ca(3'b001, 32'h0);
    rc(4'h5, 32'h3f);
    acc(32'h0430c010, 0, 0, 2, 1);
    ca(3'b100, 32'h8430c010);
    acc(32'h04308010, 0, 0, 2, 1);
    ca(3'b001, 32'h0);
    chk("walks", 32'h5, walks);
    acc(32'h04308010, 0, 0, 2);
    ca(3'b100, 32'h84308010);
    wr(4'h1, 0, 32'h101);
    acc(32'h04304010, 1, 0, 2);
    ca(3'b100, 32'h84304010);
    acc(32'h04304010, 1, 0, 2, 1);
    ca(3'b001, 32'h0);
    acc(32'h08300c10, 0, 0, 2);
    ca(3'b100, 32'h88300c10);
    acc(32'h0c300410, 1, 0, 2);
    ca(3'b100, 32'h8c300010);
    print_verdict;
  end
endmodule
`default_nettype wire
